// File: hdl/tpc_pkg.sv
// constants shared by the transceiver pin control glue
// assumes a 100 MHz main clock and a link clock of 512 times the sample rate
package tpc_pkg;

  // main clock
  localparam int CLK_PERIOD_NS = 10;

  // pre-emphasis pin is left floating this long after reset before the strap is taken
  localparam int STRAP_SETTLE_NS = 1000;
  localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // bypass clock is declared absent after this long without an edge
  localparam int EXT_CLK_TIMEOUT_NS = 1000;
  localparam int EXT_CLK_TIMEOUT_CYC = EXT_CLK_TIMEOUT_NS / CLK_PERIOD_NS;

  localparam int CNT_W = 8;

  // i2c slave address layout
  localparam int I2C_ADDR_W = 7;
  localparam int ADDR_BIT0_POS = 0;
  localparam int ADDR_BIT1_POS = 1;
  localparam int ADDR_BIT2_POS = 2;
  // upper address bits, value is arbitrary
  localparam logic [3:0] I2C_ADDR_HIGH = 4'h2;

  // channel status emphasis field
  localparam int PREEMPHASIS_FLAG_PIN_W = 3;
  localparam logic [2:0] PREEMPHASIS_FLAG_PIN_CODE_50_15 = 3'h1;
  localparam logic PREEMPHASIS_FLAG_PIN_LEVEL_50_15 = 1'b0;
  localparam logic PREEMPHASIS_FLAG_PIN_LEVEL_OTHER = 1'b1;

  // clock source selection
  localparam int CLK_SRC_W = 2;
  localparam logic [1:0] CLK_SRC_BYPASS = 2'h3;

  // recovered clock divider in the link domain
  localparam int LINK_DIV_W = 2;
  localparam int DIV_BIT_256X = 0;
  localparam int DIV_BIT_128X = 1;

  typedef enum logic [2:0] {
    ST_STRAP_WAIT = 3'b001,
    ST_STRAP_TAKE = 3'b010,
    ST_RUN = 3'b100
  } tpc_strap_e;

endpackage

// File: hdl/tpc_sync.sv
// two-flop level synchroniser, one per bit
// assumes d is a level from another domain or a pin
`timescale 1ns/1ps
module tpc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_q, s1_d, s2_q, s2_d;
    always_comb begin
      s1_d = ce ? d[i] : s1_q;
      s2_d = ce ? s1_q : s2_q;
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
      end else begin
        s1_q <= s1_d;
        s2_q <= s2_d;
      end
    end
    assign q[i] = s2_q;
  end

endmodule

// File: hdl/tpc_recovered_master_clk_pin.sv
// recovered master clock pin driver, clocked by the pll clock
// assumes link_clk runs at 512 times the sample rate while the pll is in use
`timescale 1ns/1ps
module tpc_recovered_master_clk_pin (
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic ratio_128,
  input wire logic bypass,
  output logic pin_o,
  output logic pin_oe
);

  logic rst_s1_q, rst_s2_q, link_rst_n;
  logic [2:0] cfg_s;
  logic ce_s, ratio_s, bypass_s;
  logic [tpc_pkg::LINK_DIV_W-1:0] div_q, div_d;
  logic out_q, out_d, oe_q, oe_d;

  // reset asserts at once and releases on the link clock
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign link_rst_n = rst_s2_q;

  tpc_sync #(.W(3)) u_cfg_sync (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .ce(1'b1),
    .d({ce, ratio_128, bypass}),
    .q(cfg_s)
  );
  assign ce_s = cfg_s[2];
  assign ratio_s = cfg_s[1];
  assign bypass_s = cfg_s[0];

  always_comb begin
    div_d = div_q;
    out_d = out_q;
    oe_d = oe_q;
    if (ce_s) begin
      // see R12
      oe_d = ~bypass_s;
      if (bypass_s) begin
        div_d = '0;
        out_d = 1'b0;
      end else begin
        div_d = div_q + 1'b1;
        // see R11
        out_d = ratio_s ? div_q[tpc_pkg::DIV_BIT_128X] : div_q[tpc_pkg::DIV_BIT_256X];
      end
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      div_q <= '0;
      out_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      div_q <= div_d;
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  assign pin_o = out_q;
  assign pin_oe = oe_q;

endmodule

// File: hdl/tpc_top.sv
// pin-level control glue of the audio transceiver: control port mode and
// addressing, shared data pin, pre-emphasis pin with strap, recovered clock pin
// assumes the control port core runs on MCLK and pins arrive asynchronously
//
// What this block does
// R1 - a falling edge on the address/select pin enters spi mode, else i2c
// R2 - in i2c mode the address/select pin level is slave address bit 0
// R3 - in spi mode the port answers only while chip select is low
// R4 - in spi mode read data is driven on the shared data-out pin
// R5 - in i2c mode the data pin only pulls low, otherwise released
// R6 - pre-emphasis pin low when channel status says 50/15 emphasis
// R7 - pre-emphasis pin high for no emphasis or any other emphasis
// R8 - strap level on pre-emphasis pin at start-up is slave address bit 2
// R9 - while reset is low all state is reset and the block is low power
// R10 - host keeps reset low until every input clock is stable
// R11 - pll in use: recovered clock out at 256x, or 128x when selected
// R12 - pll bypassed: recovered clock pin is an input fed at 256x
// R13 - channel select 0 shows channel a, 1 shows channel b on the pin
// R14 - spi mode once entered is kept until the next reset
`timescale 1ns/1ps
module tpc_top (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic PLL_CLK,
  input wire logic ADDR_BIT0_PIN,
  input wire logic ADDR_BIT1_PIN,
  input wire logic SPI_DATA_OUT_PIN_I,
  output logic SPI_DATA_OUT_PIN_O,
  output logic SPI_DATA_OUT_PIN_OE,
  input wire logic PREEMPHASIS_FLAG_PIN_I,
  output logic PREEMPHASIS_FLAG_PIN_O,
  output logic PREEMPHASIS_FLAG_PIN_OE,
  input wire logic RECOVERED_MASTER_CLK_PIN_I,
  output logic RECOVERED_MASTER_CLK_PIN_O,
  output logic RECOVERED_MASTER_CLK_PIN_OE,
  input wire logic I2C_SDA_PULL_LOW,
  input wire logic SPI_READ_DATA,
  input wire logic STATUS_CHANNEL_SELECT,
  input wire logic [tpc_pkg::PREEMPHASIS_FLAG_PIN_W-1:0] PREEMPHASIS_FLAG_PIN_CODE_A,
  input wire logic [tpc_pkg::PREEMPHASIS_FLAG_PIN_W-1:0] PREEMPHASIS_FLAG_PIN_CODE_B,
  input wire logic [tpc_pkg::CLK_SRC_W-1:0] CLK_SRC_SEL,
  input wire logic RECOVERED_MASTER_CLK_PIN_RATIO_128,
  output logic SPI_MODE,
  output logic SPI_SELECTED,
  output logic I2C_SDA_IN,
  output logic [tpc_pkg::I2C_ADDR_W-1:0] I2C_SLAVE_ADDR,
  output logic ADDR_BIT2_STRAP,
  output logic STRAP_DONE,
  output logic LOW_POWER,
  output logic EXT_CLK_PRESENT
);

  // synchronised pin levels
  logic [4:0] pin_s;
  logic ad0_s, ad1_s, sda_s, preemphasis_flag_pin_s, recovered_master_clk_pin_s;

  // control port mode
  logic ad0_prev_q, ad0_prev_d;
  logic spi_mode_q, spi_mode_d;
  logic ad0_fall;

  // strap capture and low power
  tpc_pkg::tpc_strap_e st_q, st_d;
  logic [tpc_pkg::CNT_W-1:0] settle_q, settle_d;
  logic strap_q, strap_d;
  logic low_power_q, low_power_d;

  // shared data pin and slave address
  logic sdo_o_q, sdo_o_d;
  logic sdo_oe_q, sdo_oe_d;
  logic [tpc_pkg::I2C_ADDR_W-1:0] addr_q, addr_d;

  // pre-emphasis pin
  // the emphasis code of the chosen channel
  logic [tpc_pkg::PREEMPHASIS_FLAG_PIN_W-1:0] preemphasis_flag_pin_sel;
  logic preemphasis_flag_pin_o_q, preemphasis_flag_pin_o_d;
  logic preemphasis_flag_pin_oe_q, preemphasis_flag_pin_oe_d;

  // recovered clock pin and the watch on the bypass clock
  logic bypass_q, bypass_d;
  logic ratio_q, ratio_d;
  logic recovered_master_clk_pin_prev_q, recovered_master_clk_pin_prev_d;
  logic [tpc_pkg::CNT_W-1:0] idle_q, idle_d;
  logic ext_ok_q, ext_ok_d;
  logic recovered_master_clk_pin_edge;

  // last count values, cut to the counter width on purpose
  localparam int SETTLE_LAST_I = tpc_pkg::STRAP_SETTLE_CYC - 1;
  localparam int IDLE_LAST_I = tpc_pkg::EXT_CLK_TIMEOUT_CYC;
  localparam logic [tpc_pkg::CNT_W-1:0] SETTLE_LAST = SETTLE_LAST_I[tpc_pkg::CNT_W-1:0];
  localparam logic [tpc_pkg::CNT_W-1:0] IDLE_LAST = IDLE_LAST_I[tpc_pkg::CNT_W-1:0];

  // clocking: everything here runs on MCLK except the recovered clock
  // divider, which runs on PLL_CLK inside tpc_recovered_master_clk_pin. only levels (bypass and
  // ratio registered, clock enable raw) cross into that domain, and each passes
  // a two-flop synchroniser there, so a change takes a few link clocks.
  // the bypass clock coming back on the recovered clock pin is watched
  // here through the pin synchroniser; this works because that clock is
  // far slower than MCLK, and a bypass clock near MCLK would alias.

  // every pin level passes two flops; the pins are not timed to MCLK
  // the address pins are read continuously, so an address change takes
  // effect a few cycles later without a reset
  tpc_sync #(.W(5)) u_pin_sync (
    .clk(MCLK),
    .rst_n(RESETN),
    .ce(CE),
    .d({RECOVERED_MASTER_CLK_PIN_I, PREEMPHASIS_FLAG_PIN_I, SPI_DATA_OUT_PIN_I,
        ADDR_BIT1_PIN, ADDR_BIT0_PIN}),
    .q(pin_s)
  );
  assign ad0_s = pin_s[0];
  assign ad1_s = pin_s[1];
  assign sda_s = pin_s[2];
  assign preemphasis_flag_pin_s = pin_s[3];
  assign recovered_master_clk_pin_s = pin_s[4];

  // control port mode
  // the edge detector resets low like the synchroniser, so a pin that idles
  // high after reset shows a rising edge and never a false falling one
  // a host that only ever uses i2c must keep this pin from falling,
  // for one falling edge is enough to leave i2c mode until reset
  assign ad0_fall = ad0_prev_q & ~ad0_s;

  always_comb begin
    ad0_prev_d = ad0_prev_q;
    spi_mode_d = spi_mode_q;
    if (CE) begin
      ad0_prev_d = ad0_s;
      // nothing clears the mode but reset
      if (ad0_fall) begin
        spi_mode_d = 1'b1; // see R1 R14
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ad0_prev_q <= 1'b0;
      spi_mode_q <= 1'b0; // see R1
    end else begin
      ad0_prev_q <= ad0_prev_d;
      spi_mode_q <= spi_mode_d;
    end
  end

  // chip select only counts once the port is in spi mode
  assign SPI_SELECTED = spi_mode_q & ~ad0_s; // see R3
  assign SPI_MODE = spi_mode_q;

  // strap capture: the pre-emphasis pin stays released until the strap is taken
  // the pin is released during reset as well, since its enable resets low
  always_comb begin
    st_d = st_q;
    settle_d = settle_q;
    strap_d = strap_q;
    low_power_d = low_power_q;
    if (CE) begin
      // low power is only a flag here; the gating itself lies elsewhere
      low_power_d = 1'b0; // see R9
      case (st_q)
        tpc_pkg::ST_STRAP_WAIT: begin
          // let the resistor settle the floating pin first
          // the settle time is far longer than the synchroniser delay
          settle_d = settle_q + 1'b1;
          if (settle_q == SETTLE_LAST) begin
            st_d = tpc_pkg::ST_STRAP_TAKE;
          end
        end
        tpc_pkg::ST_STRAP_TAKE: begin
          strap_d = preemphasis_flag_pin_s; // see R8
          st_d = tpc_pkg::ST_RUN;
        end
        tpc_pkg::ST_RUN: begin
          st_d = tpc_pkg::ST_RUN;
        end
        default: begin
          st_d = tpc_pkg::ST_STRAP_WAIT;
          settle_d = '0;
        end
      endcase
    end
  end

  // the strap is sampled once per reset; a later change on the pin is ignored
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      st_q <= tpc_pkg::ST_STRAP_WAIT; // see R9
      settle_q <= '0;
      strap_q <= 1'b0;
      low_power_q <= 1'b1;
    end else begin
      st_q <= st_d;
      settle_q <= settle_d;
      strap_q <= strap_d;
      low_power_q <= low_power_d;
    end
  end

  assign STRAP_DONE = (st_q == tpc_pkg::ST_RUN);
  assign ADDR_BIT2_STRAP = strap_q;
  assign LOW_POWER = low_power_q;

  // shared data pin and slave address
  // a deselected spi port lets the pin go; the host must not rely on
  // the last bit staying on it
  always_comb begin
    sdo_o_d = sdo_o_q;
    sdo_oe_d = sdo_oe_q;
    addr_d = addr_q;
    if (CE) begin
      if (spi_mode_q) begin
        // push-pull read data, driven only while selected
        sdo_o_d = SPI_READ_DATA; // see R4
        sdo_oe_d = ~ad0_s; // see R3 R4
      end else begin
        // open drain: the low level is the only one ever driven
        sdo_o_d = 1'b0; // see R5
        sdo_oe_d = I2C_SDA_PULL_LOW; // see R5
      end
      // upper address bits are fixed; bit 1 follows its own pin
      addr_d[tpc_pkg::I2C_ADDR_W-1:tpc_pkg::ADDR_BIT2_POS+1] = tpc_pkg::I2C_ADDR_HIGH;
      addr_d[tpc_pkg::ADDR_BIT2_POS] = strap_d; // see R8
      addr_d[tpc_pkg::ADDR_BIT1_POS] = ad1_s;
      addr_d[tpc_pkg::ADDR_BIT0_POS] = ad0_s; // see R2
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      sdo_o_q <= 1'b0;
      sdo_oe_q <= 1'b0;
      addr_q <= '0;
    end else begin
      sdo_o_q <= sdo_o_d;
      sdo_oe_q <= sdo_oe_d;
      addr_q <= addr_d;
    end
  end

  assign SPI_DATA_OUT_PIN_O = sdo_o_q;
  assign SPI_DATA_OUT_PIN_OE = sdo_oe_q;
  assign I2C_SDA_IN = sda_s;
  assign I2C_SLAVE_ADDR = addr_q;

  // pre-emphasis pin
  always_comb begin
    if (STATUS_CHANNEL_SELECT) begin
      preemphasis_flag_pin_sel = PREEMPHASIS_FLAG_PIN_CODE_B; // see R13
    end else begin
      preemphasis_flag_pin_sel = PREEMPHASIS_FLAG_PIN_CODE_A; // see R13
    end
  end

  // the level follows the code with one cycle of delay; no filtering
  // is done, so a glitching code shows on the pin
  always_comb begin
    preemphasis_flag_pin_o_d = preemphasis_flag_pin_o_q;
    preemphasis_flag_pin_oe_d = preemphasis_flag_pin_oe_q;
    if (CE) begin
      if (preemphasis_flag_pin_sel == tpc_pkg::PREEMPHASIS_FLAG_PIN_CODE_50_15) begin
        preemphasis_flag_pin_o_d = tpc_pkg::PREEMPHASIS_FLAG_PIN_LEVEL_50_15; // see R6
      end else begin
        preemphasis_flag_pin_o_d = tpc_pkg::PREEMPHASIS_FLAG_PIN_LEVEL_OTHER; // see R7
      end
      // the pin turns to an output only after the strap has been read
      preemphasis_flag_pin_oe_d = (st_d == tpc_pkg::ST_RUN); // see R8
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      preemphasis_flag_pin_o_q <= tpc_pkg::PREEMPHASIS_FLAG_PIN_LEVEL_OTHER;
      preemphasis_flag_pin_oe_q <= 1'b0;
    end else begin
      preemphasis_flag_pin_o_q <= preemphasis_flag_pin_o_d;
      preemphasis_flag_pin_oe_q <= preemphasis_flag_pin_oe_d;
    end
  end

  assign PREEMPHASIS_FLAG_PIN_O = preemphasis_flag_pin_o_q;
  assign PREEMPHASIS_FLAG_PIN_OE = preemphasis_flag_pin_oe_q;

  // clock source selection, registered so the link domain sees clean levels
  // the ratio change takes effect on the next divider step, so one
  // output period may come out short
  assign recovered_master_clk_pin_edge = recovered_master_clk_pin_s & ~recovered_master_clk_pin_prev_q;

  always_comb begin
    bypass_d = bypass_q;
    ratio_d = ratio_q;
    recovered_master_clk_pin_prev_d = recovered_master_clk_pin_prev_q;
    idle_d = idle_q;
    ext_ok_d = ext_ok_q;
    if (CE) begin
      bypass_d = (CLK_SRC_SEL == tpc_pkg::CLK_SRC_BYPASS); // see R12
      ratio_d = RECOVERED_MASTER_CLK_PIN_RATIO_128; // see R11
      recovered_master_clk_pin_prev_d = recovered_master_clk_pin_s;
      // the count saturates, so a stopped clock reads absent for good
      // a missing bypass clock is reported, not acted on
      if (!bypass_q || recovered_master_clk_pin_edge) begin
        idle_d = '0;
      end else if (idle_q != IDLE_LAST) begin
        idle_d = idle_q + 1'b1;
      end
      ext_ok_d = bypass_q && (idle_q != IDLE_LAST); // see R12
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      bypass_q <= 1'b0;
      ratio_q <= 1'b0;
      recovered_master_clk_pin_prev_q <= 1'b0;
      idle_q <= '0;
      ext_ok_q <= 1'b0;
    end else begin
      bypass_q <= bypass_d;
      ratio_q <= ratio_d;
      recovered_master_clk_pin_prev_q <= recovered_master_clk_pin_prev_d;
      idle_q <= idle_d;
      ext_ok_q <= ext_ok_d;
    end
  end

  assign EXT_CLK_PRESENT = ext_ok_q;

  // recovered clock pin, run from the pll clock in its own domain
  // while bypassed the pin is released and the host's clock comes in
  // the enable is passed on raw; tpc_recovered_master_clk_pin synchronises it with the rest
  tpc_recovered_master_clk_pin u_recovered_master_clk_pin (
    .link_clk(PLL_CLK),
    .rst_n(RESETN),
    .ce(CE),
    .ratio_128(ratio_q),
    .bypass(bypass_q),
    .pin_o(RECOVERED_MASTER_CLK_PIN_O),
    .pin_oe(RECOVERED_MASTER_CLK_PIN_OE)
  );

endmodule

// File: test/tpc_top_assertions.sv
// checker on the pin glue top ports
// assumes a bind onto tpc_top, link clock on PLL_CLK
`timescale 1ns/1ps
module tpc_chk (
  input logic MCLK,
  input logic RESETN,
  input logic PLL_CLK,
  input logic ADDR_BIT0_PIN,
  input logic SPI_DATA_OUT_PIN_O,
  input logic SPI_DATA_OUT_PIN_OE,
  input logic RECOVERED_MASTER_CLK_PIN_OE,
  input logic [tpc_pkg::CLK_SRC_W-1:0] CLK_SRC_SEL,
  input logic SPI_MODE,
  input logic SPI_SELECTED,
  input logic [tpc_pkg::I2C_ADDR_W-1:0] I2C_SLAVE_ADDR,
  input logic STRAP_DONE
);
  logic byp;
  assign byp = CLK_SRC_SEL == tpc_pkg::CLK_SRC_BYPASS;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  a_spi_keep: assert property (SPI_MODE |=> SPI_MODE)
    else $error("spi lost");
  a_spi_in: assert property ($fell(ADDR_BIT0_PIN) |-> ##[1:8] SPI_MODE)
    else $error("no spi");
  a_sda_drain: assert property (!SPI_MODE && SPI_DATA_OUT_PIN_OE |-> !SPI_DATA_OUT_PIN_O)
    else $error("sda high");
  a_addr_low: assert property ((STRAP_DONE && !SPI_MODE && $stable(ADDR_BIT0_PIN))[*5]
    |-> I2C_SLAVE_ADDR[0] == ADDR_BIT0_PIN) else $error("addr");
  a_cs_idle: assert property ((SPI_MODE && ADDR_BIT0_PIN)[*5] |-> !SPI_SELECTED)
    else $error("cs idle");
  a_cs_sel: assert property ((SPI_MODE && !ADDR_BIT0_PIN)[*5] |-> SPI_SELECTED)
    else $error("cs sel");
  a_ck_in: assert property (@(posedge PLL_CLK) disable iff (!RESETN) byp[*8] |->
    !RECOVERED_MASTER_CLK_PIN_OE) else $error("ck driven");
  a_ck_out: assert property (@(posedge PLL_CLK) disable iff (!RESETN) (!byp)[*8] |->
    RECOVERED_MASTER_CLK_PIN_OE) else $error("ck idle");
endmodule

// File: test/tpc_host.sv
// host side: chip select and the bypass clock on the recovered clock pin
// assumes PLL_CLK runs at 512 times the sample rate
`timescale 1ns/1ps
module tpc_host (
  input wire logic PLL_CLK,
  input wire logic cs_low,
  input wire logic RECOVERED_MASTER_CLK_PIN_O,
  input wire logic RECOVERED_MASTER_CLK_PIN_OE,
  output logic ADDR_BIT0_PIN,
  output logic RECOVERED_MASTER_CLK_PIN_I
);
  logic ext_q = 1'h0;
  assign ADDR_BIT0_PIN = !cs_low;
  // half the link rate gives 256 times the sample rate
  always @(posedge PLL_CLK) ext_q <= !ext_q;
  assign RECOVERED_MASTER_CLK_PIN_I =
    RECOVERED_MASTER_CLK_PIN_OE ? RECOVERED_MASTER_CLK_PIN_O : ext_q;
endmodule

// File: test/transceiver_pin_control_glue_tb_top.sv
// bench for the pin glue with pull-ups on the data and emphasis pins
// assumes tpc_top, tpc_host and tpc_chk are compiled first
`timescale 1ns/1ps
module transceiver_pin_control_glue_tb_top;
  logic MCLK = 1'h0, PLL_CLK = 1'h0, RESETN = 1'h0, CE = 1'h1, ADDR_BIT1_PIN = 1'h0;
  logic I2C_SDA_PULL_LOW = 1'h0, SPI_READ_DATA = 1'h0, STATUS_CHANNEL_SELECT = 1'h0;
  logic RECOVERED_MASTER_CLK_PIN_RATIO_128 = 1'h0, cs_low = 1'h0, SPI_DATA_OUT_PIN_O, SPI_DATA_OUT_PIN_OE;
  logic PREEMPHASIS_FLAG_PIN_O, PREEMPHASIS_FLAG_PIN_OE, RECOVERED_MASTER_CLK_PIN_O;
  logic RECOVERED_MASTER_CLK_PIN_OE, SPI_MODE, SPI_SELECTED, I2C_SDA_IN, ADDR_BIT2_STRAP;
  logic STRAP_DONE, LOW_POWER, EXT_CLK_PRESENT;
  logic [tpc_pkg::PREEMPHASIS_FLAG_PIN_W-1:0] PREEMPHASIS_FLAG_PIN_CODE_A = '0, PREEMPHASIS_FLAG_PIN_CODE_B = '0;
  logic [tpc_pkg::CLK_SRC_W-1:0] CLK_SRC_SEL = '0;
  logic [tpc_pkg::I2C_ADDR_W-1:0] I2C_SLAVE_ADDR;
  wire ADDR_BIT0_PIN, RECOVERED_MASTER_CLK_PIN_I;
  wire SPI_DATA_OUT_PIN_I = !(SPI_DATA_OUT_PIN_OE && !SPI_DATA_OUT_PIN_O);
  wire PREEMPHASIS_FLAG_PIN_I = PREEMPHASIS_FLAG_PIN_OE ? PREEMPHASIS_FLAG_PIN_O : 1'h1;
  int err_total = 0, num_checks = 0;
  tpc_top i_tpc_top (.*);
  tpc_host i_tpc_host (.*);
  initial forever #5 MCLK = ~MCLK;
  initial #37 forever #80 PLL_CLK = ~PLL_CLK;
  task automatic chk(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge MCLK);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic do_reset;
    @(posedge MCLK) RESETN <= 1'h0;
    w(16);
    chk(LOW_POWER, 1'h1);
    @(posedge MCLK) RESETN <= 1'h1;
    for (int i = 0; i < 300 && STRAP_DONE !== 1'h1; i++) w(1);
    chk(SPI_MODE, 1'h0);
    chk(I2C_SLAVE_ADDR[2], 1'h1);
    chk(I2C_SLAVE_ADDR[0], 1'h1);
    chk(STRAP_DONE, 1'h1);
    chk(ADDR_BIT2_STRAP, 1'h1);
    chk(PREEMPHASIS_FLAG_PIN_OE, 1'h1);
    chk(LOW_POWER, 1'h0);
  endtask
  task automatic t_i2c;
    @(posedge MCLK) I2C_SDA_PULL_LOW <= 1'h1;
    w(8);
    chk(I2C_SDA_IN, 1'h0);
    @(posedge MCLK) I2C_SDA_PULL_LOW <= 1'h0;
    w(8);
    chk(SPI_DATA_OUT_PIN_OE, 1'h0);
  endtask
  task automatic t_preemphasis_flag_pin;
    logic [2:0] s;
    for (int c = 0; c < 8; c++) begin
      @(posedge MCLK);
      PREEMPHASIS_FLAG_PIN_CODE_A <= ~c[2:0];
      PREEMPHASIS_FLAG_PIN_CODE_B <= c[2:0];
      STATUS_CHANNEL_SELECT <= c[0];
      w(8);
      s = c[0] ? c[2:0] : ~c[2:0];
      chk(PREEMPHASIS_FLAG_PIN_I, s != tpc_pkg::PREEMPHASIS_FLAG_PIN_CODE_50_15);
    end
  endtask
  task automatic t_recovered_master_clk_pin;
    logic s;
    chk(RECOVERED_MASTER_CLK_PIN_OE, 1'h1);
    @(negedge PLL_CLK) s = RECOVERED_MASTER_CLK_PIN_O;
    @(negedge PLL_CLK) chk(RECOVERED_MASTER_CLK_PIN_O, !s);
    @(posedge MCLK) CLK_SRC_SEL <= tpc_pkg::CLK_SRC_BYPASS;
    w(200);
    chk(RECOVERED_MASTER_CLK_PIN_OE, 1'h0);
    chk(EXT_CLK_PRESENT, 1'h1);
  endtask
  task automatic t_spi;
    @(posedge MCLK) cs_low <= 1'h1;
    w(10);
    chk(SPI_SELECTED, 1'h1);
    chk(SPI_DATA_OUT_PIN_I, 1'h0);
    @(posedge MCLK) SPI_READ_DATA <= 1'h1;
    w(4);
    chk(SPI_DATA_OUT_PIN_O, 1'h1);
    @(posedge MCLK) SPI_READ_DATA <= 1'h0;
    w(1);
    @(posedge MCLK) cs_low <= 1'h0;
    w(10);
    chk(SPI_SELECTED, 1'h0);
    chk(SPI_MODE, 1'h1);
  endtask
  initial begin
    repeat (6000) @(posedge MCLK);
    err_total++;
    wrap_up();
  end
  initial begin
    do_reset();
    t_i2c();
    t_preemphasis_flag_pin();
    t_recovered_master_clk_pin();
    t_spi();
    do_reset();
    wrap_up();
  end
endmodule
bind tpc_top tpc_chk i_tpc_chk (.*);
